/* File: design/timer_a_channel.sv */
// One 16-bit timer A channel: interval timer and event counter modes,
// two-phase decode and Z-phase counter reset, behind a Wishbone slave.
// Assumes neighbour overflow inputs come from logic on REF_CLK_IN; pins are
// asynchronous and pass two flip-flops before use.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

module timer_a_channel #(
    parameter int CHANNEL = 3
) (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic SRST_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // Pins
    input wire logic CHAN_IN_PIN_IN,
    input wire logic CHAN_OUT_PIN_IN,
    output logic CHAN_OUT_PIN_OUT,
    output logic CHAN_OUT_PIN_OE_N_OUT,
    input wire logic ZPHASE_IRQ_PIN_N_IN,
    input wire logic LOW_SPEED_CLK_IN,
    // Neighbour timers, same clock
    input wire logic TB2_OVF_IN,
    input wire logic PREV_OVF_IN,
    input wire logic NEXT_OVF_IN,
    // Events out
    output logic OVF_OUT,
    output logic TIMER_IRQ_OUT
);

    localparam bit HAS_NORMAL = (CHANNEL == 2) || (CHANNEL == 3);
    localparam bit HAS_MUL4 = (CHANNEL == 3) || (CHANNEL == 4);

    // Byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [15:0] counter;
    logic [15:0] reload;
    logic run;
    timer_a_pkg::mode_cfg_t cfg;
    logic [3:0] prescale;
    logic zphase_en;
    logic zphase_pol;
    logic out_level;
    logic z_pending;
    logic last_up;
    logic irq_second;
    logic ack;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_hit = WB_CYC_IN & WB_STB_IN;
    wire wr_fire = bus_hit & WB_WE_IN & ack;
    wire wr_counter = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_COUNTER);
    wire wr_run = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_RUN);
    wire wr_mode = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_MODE);
    wire wr_presc = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_PRESCALE);
    wire wr_trig = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_TRIGOPT);
    wire wr_zctrl = wr_fire & (WB_ADR_IN == timer_a_pkg::ADDR_ZCTRL);
    wire [31:0] merged_cnt = lane_merge({16'h0000, reload}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] merged_mode = lane_merge({16'h0000, cfg}, WB_DAT_IN, WB_SEL_IN);
    timer_a_pkg::status_t status;
    assign status = '{last_up: last_up, z_pending: z_pending, out_level: out_level,
                      running: run};

    // Read mux; unmapped addresses read as zero and are still acknowledged
    logic [31:0] read_mux;
    always_comb begin
        case (WB_ADR_IN)
            timer_a_pkg::ADDR_COUNTER: read_mux = {16'h0000, counter};
            timer_a_pkg::ADDR_RUN: read_mux = {31'h00000000, run};
            timer_a_pkg::ADDR_MODE: read_mux = {16'h0000, cfg};
            timer_a_pkg::ADDR_PRESCALE: read_mux = {28'h0000000, prescale};
            timer_a_pkg::ADDR_TRIGOPT: read_mux = {31'h00000000, zphase_en};
            timer_a_pkg::ADDR_ZCTRL: read_mux = {31'h00000000, zphase_pol};
            timer_a_pkg::ADDR_STATUS: read_mux = {28'h0000000, status};
            default: read_mux = 32'h00000000;
        endcase
    end

    // Ack one cycle after the request; writes land at the acknowledged edge
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack <= bus_hit & ~ack;
            rdata <= read_mux;
        end
    end
    assign WB_ACK_OUT = ack;
    assign WB_DAT_OUT = rdata;

    // Control registers
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            run <= 1'b0;
            cfg <= timer_a_pkg::MODE_RST;
            prescale <= timer_a_pkg::PRESCALE_RST;
            zphase_en <= 1'b0;
            zphase_pol <= 1'b0;
        end else begin
            if (wr_run && WB_SEL_IN[0]) begin
                run <= WB_DAT_IN[timer_a_pkg::RUN_BIT_POS];
            end
            if (wr_mode) begin
                cfg <= merged_mode[15:0];
            end
            if (wr_presc && WB_SEL_IN[0]) begin
                prescale <= WB_DAT_IN[timer_a_pkg::PRESCALE_MSB:0];
            end
            if (wr_trig && WB_SEL_IN[0]) begin
                zphase_en <= WB_DAT_IN[timer_a_pkg::ZEN_BIT_POS];
            end
            if (wr_zctrl && WB_SEL_IN[0]) begin
                zphase_pol <= WB_DAT_IN[timer_a_pkg::ZPOL_BIT_POS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 input pin, 1 output pin as input, 2 Z-phase, 3 low-speed
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            sync1 <= 4'h4; // Z pin idles high, so no false edge after reset
            sync2 <= 4'h4;
            sync3 <= 4'h4;
        end else begin
            sync1 <= {LOW_SPEED_CLK_IN, ZPHASE_IRQ_PIN_N_IN, CHAN_OUT_PIN_IN, CHAN_IN_PIN_IN};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    wire [3:0] rise = sync2 & ~sync3;
    wire [3:0] fall = ~sync2 & sync3;
    wire pha = sync2[0];
    wire phb = sync2[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Count source dividers; they run free so the first tick may come early
    logic [2:0] div8_cnt;
    logic [4:0] presc_cnt;
    wire [4:0] presc_last = {prescale, 1'b0} - 5'h01;
    wire presc_tick = (prescale == 4'h0) | (presc_cnt >= presc_last);
    wire div8_tick = (div8_cnt == timer_a_pkg::DIV8_LAST);
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            div8_cnt <= 3'h0;
            presc_cnt <= 5'h00;
        end else begin
            div8_cnt <= div8_cnt + 3'h1;
            presc_cnt <= presc_tick ? 5'h00 : presc_cnt + 5'h01;
        end
    end

    // Interval timer source select
    logic timer_tick;
    always_comb begin
        case (cfg.src_sel)
            timer_a_pkg::SRC_UNDIV: timer_tick = 1'b1;
            timer_a_pkg::SRC_DIV8: timer_tick = div8_tick;
            timer_a_pkg::SRC_PRESCALED: timer_tick = presc_tick;
            default: timer_tick = rise[3];
        endcase
    end

    // Event source select, previous and next channel wrap by system wiring
    logic evt_tick;
    always_comb begin
        case (cfg.evt_sel)
            timer_a_pkg::EVT_PIN: evt_tick = cfg.edge_rise ? rise[0] : fall[0];
            timer_a_pkg::EVT_TB2: evt_tick = TB2_OVF_IN;
            timer_a_pkg::EVT_PREV: evt_tick = PREV_OVF_IN;
            default: evt_tick = NEXT_OVF_IN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two-phase decode; method fixed by channel where only one is offered
    wire is_timer = (cfg.mode == timer_a_pkg::MODE_TIMER);
    wire is_event = (cfg.mode == timer_a_pkg::MODE_EVENT);
    wire two_ph = is_event & cfg.two_phase & (HAS_NORMAL | HAS_MUL4);
    wire mul4 = (CHANNEL == 4) ? 1'b1 : ((CHANNEL == 3) ? cfg.mul4 : 1'b0);
    wire norm_up = rise[0] & phb;
    wire norm_dn = fall[0] & phb;
    wire m4_up = (rise[0] & phb) | (fall[1] & ~pha) | (rise[1] & pha)
        | (fall[0] & ~phb);
    wire m4_dn = (rise[0] & ~phb) | (fall[0] & phb) | (fall[1] & pha)
        | (rise[1] & ~pha);
    wire quad_up = mul4 ? m4_up : norm_up;
    wire quad_dn = mul4 ? m4_dn : norm_dn;

    // Single-phase direction: pin low counts down, high counts up
    wire single_up = cfg.dir_from_pin ? phb : cfg.dir_up;
    wire gate_ok = ~cfg.gate_en | (pha == cfg.gate_level);

    // Counting steps; one-shot and PWM modes hold the counter
    wire step_dn = run & ((is_timer & timer_tick & gate_ok)
        | (is_event & ~two_ph & evt_tick & ~single_up)
        | (two_ph & quad_dn & ~quad_up));
    wire step_up = run & ((is_event & ~two_ph & evt_tick & single_up)
        | (two_ph & quad_up & ~quad_dn));
    wire at_zero = (counter == 16'h0000);
    wire at_max = (counter == timer_a_pkg::COUNT_MAX);
    wire ovf_evt = (step_dn & at_zero) | (step_up & at_max);

    ////////////////////////////////////////////////////////////////////////////////
    // Z-phase reset
    wire z_allowed = (CHANNEL == 3) & two_ph & cfg.free_run & mul4 & zphase_en;
    wire z_edge = zphase_pol ? rise[2] : fall[2];
    wire z_fire = z_pending & (step_up | step_dn);
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            z_pending <= 1'b0;
        end else if (z_edge & z_allowed) begin
            z_pending <= 1'b1; // New pulse wins over the clear
        end else if (z_fire | ~z_allowed) begin
            z_pending <= 1'b0;
        end
    end

    // Counter next value
    logic [15:0] next_counter;
    always_comb begin
        next_counter = counter;
        if (wr_counter & ~run) begin
            next_counter = merged_cnt[15:0];
        end else if (z_fire) begin
            next_counter = 16'h0000;
        end else if (step_dn) begin
            if (at_zero) begin
                next_counter = (is_timer | ~cfg.free_run) ? reload
                    : timer_a_pkg::COUNT_MAX;
            end else begin
                next_counter = counter - 16'h0001;
            end
        end else if (step_up) begin
            if (at_max) begin
                next_counter = cfg.free_run ? 16'h0000 : reload;
            end else begin
                next_counter = counter + 16'h0001;
            end
        end
    end

    // Counter, reload and event outputs
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            counter <= timer_a_pkg::COUNTER_RST;
            reload <= timer_a_pkg::COUNTER_RST;
            last_up <= 1'b0;
            irq_second <= 1'b0;
            OVF_OUT <= 1'b0;
            TIMER_IRQ_OUT <= 1'b0;
        end else begin
            counter <= next_counter;
            if (wr_counter) begin
                reload <= merged_cnt[15:0];
            end
            if (step_up | step_dn) begin
                last_up <= step_up;
            end
            irq_second <= ovf_evt & z_fire;
            OVF_OUT <= ovf_evt;
            TIMER_IRQ_OUT <= ovf_evt | z_fire | irq_second;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse output; the pin is released whenever it serves as an input
    wire pin_is_input = is_event & (cfg.dir_from_pin | two_ph);
    wire drive = cfg.pulse_en & (is_timer | is_event) & ~pin_is_input;
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            out_level <= 1'b0;
        end else if (~run) begin
            out_level <= 1'b0;
        end else if (ovf_evt & drive) begin
            out_level <= ~out_level;
        end
    end
    assign CHAN_OUT_PIN_OUT = out_level & drive;
    assign CHAN_OUT_PIN_OE_N_OUT = ~drive;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking chk_clk @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);

    AST_TIMER_RELOAD: assert property (
        step_dn & is_timer & at_zero & ~wr_counter |=> counter == $past(reload) && TIMER_IRQ_OUT
    ) else $error("Timer underflow did not reload or request");

    AST_TIMER_DECREMENT: assert property (
        step_dn & ~at_zero & ~wr_counter & ~z_fire |=> counter == $past(counter) - 16'h0001
    ) else $error("Counter did not decrement on tick");

    AST_STOPPED_HOLDS: assert property (
        ~run & ~wr_counter |=> $stable(counter)
    ) else $error("Counter moved while stopped");

    AST_STOPPED_WRITE: assert property (
        wr_counter & ~run |=> counter == reload
    ) else $error("Stopped write did not load counter and reload");

    AST_RUNNING_WRITE: assert property (
        wr_counter & run & ~step_dn & ~step_up & ~z_fire |=> $stable(counter)
    ) else $error("Running write changed the counter");

    AST_GATE_HOLD: assert property (
        run & is_timer & cfg.gate_en & (pha != cfg.gate_level) & ~wr_counter
        |=> $stable(counter)
    ) else $error("Gated timer moved");

    AST_OUT_LOW_STOPPED: assert property (
        ~run |=> CHAN_OUT_PIN_OUT == 1'b0
    ) else $error("Output pin high while stopped");

    AST_OUT_TOGGLE: assert property (
        run & ovf_evt & drive & $stable(cfg) ##1 run |-> out_level != $past(out_level)
    ) else $error("Output did not toggle on wrap");

    AST_DIV8_SPACING: assert property (
        div8_tick |=> !div8_tick [*7] ##1 div8_tick
    ) else $error("Divide-by-8 tick spacing wrong");

    AST_FREE_RUN_WRAP: assert property (
        step_up & at_max & cfg.free_run & ~wr_counter |=> counter == 16'h0000 ##0 OVF_OUT
    ) else $error("Free-run overflow did not wrap");

    AST_ZPHASE_CLEAR: assert property (
        z_fire & ~wr_counter |=> counter == 16'h0000
    ) else $error("Z-phase did not clear counter");

    AST_DOUBLE_IRQ: assert property (
        ovf_evt & z_fire |=> TIMER_IRQ_OUT ##1 TIMER_IRQ_OUT
    ) else $error("Coinciding wrap and Z-phase missed a request");

    COV_TIMER_UNDERFLOW: cover property (step_dn & is_timer & at_zero);
    COV_EVENT_OVERFLOW: cover property (step_up & at_max);
    COV_ZPHASE_RESET: cover property (z_fire);
    COV_QUAD_DOWN: cover property (two_ph & run & quad_dn);

endmodule

/* File: design/timer_a_pkg.sv */
// Constants, register map and field layouts of the timer A counter channel.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package timer_a_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_COUNTER = 8'h00;  // counter_reload_reg
    localparam logic [7:0] ADDR_RUN = 8'h04;      // count_run_reg
    localparam logic [7:0] ADDR_MODE = 8'h08;     // channel_mode_reg
    localparam logic [7:0] ADDR_PRESCALE = 8'h0C; // prescale_reg
    localparam logic [7:0] ADDR_TRIGOPT = 8'h10;  // trigger_option_reg
    localparam logic [7:0] ADDR_ZCTRL = 8'h14;    // zphase_irq_ctrl_reg
    localparam logic [7:0] ADDR_STATUS = 8'h18;   // live channel state

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of the single-bit registers and the top bit of the prescale field
    localparam int RUN_BIT_POS = 0;       // count_run_bit
    localparam int ZEN_BIT_POS = 0;       // zphase_enable_bit
    localparam int ZPOL_BIT_POS = 0;      // edge_polarity_bit, 1 = rising edge
    localparam int PRESCALE_MSB = 3;      // prescale_field_msb

    ////////////////////////////////////////////////////////////////////////////////
    // Encodings
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [1:0] SRC_UNDIV = 2'h0;      // undivided_clock
    localparam logic [1:0] SRC_DIV8 = 2'h1;       // div8_clock
    localparam logic [1:0] SRC_PRESCALED = 2'h2;  // prescaled_clock
    localparam logic [1:0] SRC_LOWSPEED = 2'h3;   // low_speed_clock
    localparam logic [1:0] EVT_PIN = 2'h0;
    localparam logic [1:0] EVT_TB2 = 2'h1;
    localparam logic [1:0] EVT_PREV = 2'h2;
    localparam logic [1:0] EVT_NEXT = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and counts
    localparam logic [15:0] COUNTER_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [3:0] PRESCALE_RST = 4'h0;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // Layout of channel_mode_reg, bit 15 down to bit 0
    typedef struct packed {
        logic rsvd;
        logic [1:0] evt_sel;
        logic mul4;
        logic two_phase;
        logic free_run;
        logic dir_up;
        logic dir_from_pin;
        logic edge_rise;
        logic pulse_en;
        logic gate_level;
        logic gate_en;
        logic [1:0] src_sel;
        logic [1:0] mode;
    } mode_cfg_t;

    // Layout of the status register, low bits
    typedef struct packed {
        logic last_up;
        logic z_pending;
        logic out_level;
        logic running;
    } status_t;

endpackage

/* File: testbench/quad_encoder_model.sv */
// Two-phase rotary encoder with a Z-phase pulse, facing the channel pins.
// Assumes step and pulse requests are levels set by the bench on its clock.
`timescale 1ns/1ps
module quad_encoder_model (
    // Bench side
    input wire logic clk_in,
    input wire logic fwd_in,
    input wire logic back_in,
    input wire logic z_in,
    // Pin side
    output logic phase_a_out,
    output logic phase_b_out,
    output logic z_n_out
);
    logic [1:0] pos = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Gray position; only one phase changes per step, as a real encoder does
    always_ff @(posedge clk_in) begin
        pos <= pos + {back_in, fwd_in | back_in};
    end
    assign phase_a_out = pos[1] ^ pos[0];
    assign phase_b_out = pos[1];
    // Pulse is held by the bench for several count periods
    assign z_n_out = !z_in;
endmodule

/* File: testbench/timer_a_interval_event_counter_test.sv */
// Self-checking bench of one timer A channel: timer, neighbour events, quadrature.
// Assumes the channel answers Wishbone in one cycle and takes every count source from the bench clock.
`timescale 1ns/1ps
module timer_a_interval_event_counter_test;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic fwd_s = 1'b0, back_s = 1'b0, z_s = 1'b0, ev_on = 1'b0;
    logic [1:0] ev_sel = 2'h0, pos = 2'h0;
    logic ack, oe_n, out_pin, ovf, irq, enc_a, enc_b, z_n, zp = 1'b0;
    logic [2:0] slow_div = 3'h0;
    logic [15:0] exp = 16'h0000;
    logic [31:0] q[$];
    int seed = 12084, num_errors = 0, tests_run = 0, i, m, n, f;
    timer_a_pkg::mode_cfg_t c;

    quad_encoder_model enc (.clk_in(clk), .fwd_in(fwd_s), .back_in(back_s), .z_in(z_s),
        .phase_a_out(enc_a), .phase_b_out(enc_b), .z_n_out(z_n));
    timer_a_channel #(.CHANNEL(3)) DUT (.REF_CLK_IN(clk), .SRST_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(dat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CHAN_IN_PIN_IN(enc_a),
        .CHAN_OUT_PIN_IN(oe_n ? enc_b : out_pin), .CHAN_OUT_PIN_OUT(out_pin),
        .CHAN_OUT_PIN_OE_N_OUT(oe_n), .ZPHASE_IRQ_PIN_N_IN(z_n),
        .LOW_SPEED_CLK_IN(slow_div[2]),
        .TB2_OVF_IN(ev_on && ev_sel == timer_a_pkg::EVT_TB2),
        .PREV_OVF_IN(ev_on && ev_sel == timer_a_pkg::EVT_PREV),
        .NEXT_OVF_IN(ev_on && ev_sel == timer_a_pkg::EVT_NEXT),
        .OVF_OUT(ovf), .TIMER_IRQ_OUT(irq));

    initial begin
        forever #20 clk = !clk;
    end

    // Low-speed clock for the timer, one eighth of the bench clock
    always @(posedge clk) slow_div <= slow_div + 3'h1;

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // Watcher: every read answer is matched against the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (q.size() == 0) cmp_word(32'hDEADBEEF, rdat);
            else cmp_word(q.pop_front(), rdat);
        end
    end

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 20) begin
            num_errors++;
            final_report();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic setup(input logic [15:0] v);
        wb(1'b1, timer_a_pkg::ADDR_RUN, 32'h0);
        wb(1'b1, timer_a_pkg::ADDR_MODE, {16'h0000, c});
        cmp_word(32'h0, {31'h0, out_pin});
        wb(1'b1, timer_a_pkg::ADDR_COUNTER, {16'h0000, v});
        rd(timer_a_pkg::ADDR_COUNTER, {16'h0000, v});
        wb(1'b1, timer_a_pkg::ADDR_RUN, 32'h1);
    endtask

    // Cycles from one wrap pulse to the next, bounded
    task automatic gap(output int g);
        int k;
        for (k = 0; k < 3000 && ovf !== 1'b1; k++) @(posedge clk);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (ovf !== 1'b1 && g < 3000);
        cmp_word(32'h1, {31'h0, irq});
        if (g >= 3000 || k >= 3000) begin
            num_errors++;
            final_report();
        end
    endtask

    // One encoder step; expected count derived from the decode rules
    task automatic step(input logic fwd, input logic x4);
        logic [1:0] o;
        logic [1:0] nw;
        o = {pos[1] ^ pos[0], pos[1]};
        pos = pos + (fwd ? 2'h1 : 2'h3);
        nw = {pos[1] ^ pos[0], pos[1]};
        if (zp) exp = 16'h0000;
        else if (x4) exp = exp + ((o[1] == o[0]) ? 16'hFFFF : 16'h0001);
        else if (o[0] & nw[0] & (o[1] != nw[1])) exp = exp + (nw[1] ? 16'h1 : 16'hFFFF);
        zp = 1'b0;
        @(posedge clk);
        fwd_s <= fwd;
        back_s <= !fwd;
        @(posedge clk);
        fwd_s <= 1'b0;
        back_s <= 1'b0;
        repeat (8) @(posedge clk);
        rd(timer_a_pkg::ADDR_COUNTER, {16'h0000, exp});
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(timer_a_pkg::ADDR_COUNTER, 32'h0);
        rd(8'h1C, 32'h0);
        wb(1'b1, timer_a_pkg::ADDR_PRESCALE, 32'h2);
        // Timer: period, running reload write, every count source
        for (i = 0; i < 5; i++) begin
            c = '0;
            c.pulse_en = 1'b1;
            c.src_sel = (i < 2) ? timer_a_pkg::SRC_UNDIV : ((i == 2) ? timer_a_pkg::SRC_PRESCALED
                : ((i == 3) ? timer_a_pkg::SRC_DIV8 : timer_a_pkg::SRC_LOWSPEED));
            f = (i < 2) ? 1 : ((i == 2) ? 4 : 8);
            m = (i == 0) ? 0 : ($random(seed) & 7);
            setup(m[15:0]);
            gap(n);
            cmp_word((m + 1) * f, n);
            wb(1'b1, timer_a_pkg::ADDR_COUNTER, m + 3);
            // Back-to-back pulses of a one-tick period may straddle the write
            gap(n);
            gap(n);
            gap(n);
            cmp_word((m + 4) * f, n);
        end
        $display("test timer done");
        // Gate: counter held while the input pin is off the gate level
        c = '0;
        c.gate_en = 1'b1;
        c.gate_level = 1'b1;
        setup(16'h0005);
        repeat (12) @(posedge clk);
        rd(timer_a_pkg::ADDR_COUNTER, 32'h5);
        @(posedge clk);
        fwd_s <= 1'b1;
        @(posedge clk);
        fwd_s <= 1'b0;
        pos = pos + 2'h1;
        gap(n);
        cmp_word(32'h6, n);
        $display("test gate done");
        // Neighbour overflow sources, counting up with reload
        for (i = 1; i < 4; i++) begin
            c = '0;
            c.mode = timer_a_pkg::MODE_EVENT;
            c.dir_up = 1'b1;
            c.evt_sel = i[1:0];
            setup(16'h0000);
            @(posedge clk);
            ev_sel <= i[1:0];
            repeat (3) begin
                @(posedge clk);
                ev_on <= 1'b1;
                @(posedge clk);
                ev_on <= 1'b0;
            end
            rd(timer_a_pkg::ADDR_COUNTER, 32'h3);
        end
        $display("test events done");
        // Quadrature, multiply-by-4 then normal, then Z-phase clear
        c = '0;
        c.mode = timer_a_pkg::MODE_EVENT;
        c.two_phase = 1'b1;
        c.free_run = 1'b1;
        for (m = 1; m >= 0; m--) begin
            c.mul4 = m[0];
            exp = 16'h0000;
            setup(16'h0000);
            for (i = 0; i < 12; i++) step(($random(seed) & 1) == 1, m[0]);
        end
        c.mul4 = 1'b1;
        exp = 16'h0000;
        setup(16'h0000);
        wb(1'b1, timer_a_pkg::ADDR_TRIGOPT, 32'h1);
        wb(1'b1, timer_a_pkg::ADDR_ZCTRL, 32'h0);
        step(1'b1, 1'b1);
        z_s <= 1'b1;
        repeat (4) @(posedge clk);
        z_s <= 1'b0;
        zp = 1'b1;
        repeat (4) @(posedge clk);
        step(1'b1, 1'b1);
        $display("test quadrature done");
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule
